// [verilog/dgrs_status_bank.sv]
// diagnostic record bank of an eight-channel input module
// assumes requests and causes synchronous to clk_sys
`timescale 1ns/1ps
module dgrs_status_bank #(
  parameter dgrs_pkg::dgrs_kind_t KIND = dgrs_pkg::KIND_AI,
  parameter int unsigned TICK_DIV = dgrs_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [7:0] reqRecord,
  input wire logic [4:0] reqIndex,
  output logic respValid,
  output logic [7:0] respData,
  output logic respErr,
  input wire logic diagEnable,
  input wire logic modFail,
  input wire logic intErr,
  input wire logic extErr,
  input wire logic auxMissing,
  input wire logic paramErr,
  input wire logic diagBufOvf,
  input wire logic commErr,
  input wire logic hwIntLost,
  input wire logic [7:0] chParamErr,
  input wire logic [7:0] chCjcInternal,
  input wire logic [7:0] chCjcDefect,
  input wire logic [7:0] chWireBreak,
  input wire logic [7:0] chIntLost,
  input wire logic [7:0] chUnder,
  input wire logic [7:0] chOver,
  output logic diagIncoming,
  output logic diagGoing,
  output logic diagActive
);
  // ****************
  // declarations
  // ****************
  dgrs_tick_if tick ();
  logic [7:0] chLive [8];
  logic [7:0] liveMap;
  logic [7:0] liveSum;
  logic [7:0] liveDet;
  logic cause;
  dgrs_pkg::dgrs_state_t state_q;
  dgrs_pkg::dgrs_state_t state_d;
  logic [7:0] sum_q;
  logic [7:0] det_q;
  logic [7:0] map_q;
  logic [7:0] ch_q [8];
  logic [31:0] ts_q;
  logic respValid_q;
  logic [7:0] respData_q;
  logic respErr_q;
  logic [7:0] rdByte;
  logic rdOk;
  logic incoming_q;
  logic going_q;
  logic active_q;
  logic take;

  // ****************
  // ticker
  // ****************
  dgrs_us_ticker #(
    .DIV(TICK_DIV)
  ) u_ticker (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .tick(tick.src)
  );

  // ****************
  // channel bytes
  // ****************
  for (genvar n = 0; n < 8; n++) begin : g_chan
    dgrs_chan_byte u_chan (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .paramErr(chParamErr[n]),
      .cjcInternal(chCjcInternal[n]),
      .cjcDefect(chCjcDefect[n]),
      .wireBreak(chWireBreak[n]),
      .intLost(chIntLost[n]),
      .under(chUnder[n]),
      .over(chOver[n]),
      .faultByte(chLive[n])
    );
    assign liveMap[n] = |chLive[n];
  end

  // ****************
  // live summary and detail
  // ****************
  always_comb begin
    liveSum = 8'h00;
    liveSum[dgrs_pkg::SUM_FAIL] = modFail;
    liveSum[dgrs_pkg::SUM_INT] = intErr;
    liveSum[dgrs_pkg::SUM_EXT] = extErr;
    liveSum[dgrs_pkg::SUM_CH] = |liveMap;
    liveSum[dgrs_pkg::SUM_AUX] = auxMissing;
    liveSum[dgrs_pkg::SUM_PAR] = paramErr;
  end
  always_comb begin
    liveDet = 8'h00;
    liveDet[dgrs_pkg::DET_OVF] = diagBufOvf;
    liveDet[dgrs_pkg::DET_COMM] = commErr;
    liveDet[dgrs_pkg::DET_LOST] = hwIntLost;
  end
  assign cause = (|liveSum) | (|liveDet);

  // ****************
  // diagnostic sequence
  // ****************
  always_comb begin
    state_d = state_q;
    case (state_q)
      dgrs_pkg::ST_IDLE: begin
        if (diagEnable && cause) begin
          state_d = dgrs_pkg::ST_ACTIVE;
        end
      end
      dgrs_pkg::ST_ACTIVE: begin
        if (!cause) begin
          state_d = dgrs_pkg::ST_GOING;
        end
      end
      dgrs_pkg::ST_GOING: begin
        state_d = dgrs_pkg::ST_IDLE;
      end
      default: begin
        state_d = dgrs_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= dgrs_pkg::ST_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      incoming_q <= 1'b0;
      going_q <= 1'b0;
      active_q <= 1'b0;
    end else if (clkEn) begin
      incoming_q <= (state_q == dgrs_pkg::ST_IDLE) && (state_d == dgrs_pkg::ST_ACTIVE);
      going_q <= (state_q == dgrs_pkg::ST_ACTIVE) && (state_d == dgrs_pkg::ST_GOING);
      active_q <= (state_d == dgrs_pkg::ST_ACTIVE);
    end
  end

  // ****************
  // record snapshot
  // ****************
  // follows live while idle, frozen while a diagnostic stands
  assign take = (state_q != dgrs_pkg::ST_ACTIVE) || (state_d == dgrs_pkg::ST_GOING);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sum_q <= 8'h00;
      det_q <= 8'h00;
      map_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        ch_q[i] <= 8'h00;
      end
    end else if (clkEn && take) begin
      sum_q <= liveSum;
      det_q <= liveDet;
      map_q <= liveMap;
      for (int i = 0; i < 8; i++) begin
        ch_q[i] <= chLive[i];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ts_q <= 32'h00000000;
    end else if (clkEn && (state_q != state_d) && (state_d != dgrs_pkg::ST_IDLE)) begin
      ts_q <= tick.usCount;
    end
  end

  // ****************
  // record read
  // ****************
  always_comb begin
    rdByte = 8'h00;
    case (reqIndex)
      dgrs_pkg::IX_SUM: rdByte = sum_q;
      dgrs_pkg::IX_CLASS: rdByte = {3'h0, 1'b1, dgrs_pkg::CLASS_ANALOG};
      dgrs_pkg::IX_DETAIL: rdByte = det_q;
      dgrs_pkg::IX_KIND: rdByte = {1'b0, KIND};
      dgrs_pkg::IX_NBITS: rdByte = dgrs_pkg::NBITS_VAL;
      dgrs_pkg::IX_NCH: rdByte = dgrs_pkg::NCH_VAL;
      dgrs_pkg::IX_MAP: rdByte = map_q;
      dgrs_pkg::IX_TS0: rdByte = ts_q[7:0];
      dgrs_pkg::IX_TS0 + 5'h01: rdByte = ts_q[15:8];
      dgrs_pkg::IX_TS0 + 5'h02: rdByte = ts_q[23:16];
      dgrs_pkg::IX_LAST: rdByte = ts_q[31:24];
      default: begin
        if (reqIndex >= dgrs_pkg::IX_CH0 && reqIndex <= dgrs_pkg::IX_CH7) begin
          rdByte = ch_q[reqIndex[2:0]];
        end
      end
    endcase
  end
  always_comb begin
    rdOk = 1'b0;
    if (reqRecord == dgrs_pkg::DR_FULL) begin
      rdOk = (reqIndex <= dgrs_pkg::IX_LAST);
    end else if (reqRecord == dgrs_pkg::DR_SHORT) begin
      rdOk = (reqIndex <= dgrs_pkg::IX_SHORT_LAST);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      respValid_q <= 1'b0;
      respData_q <= 8'h00;
      respErr_q <= 1'b0;
    end else if (clkEn) begin
      respValid_q <= reqValid;
      if (reqValid && reqWrite) begin
        respData_q <= 8'h00;
        respErr_q <= 1'b1;
      end else if (reqValid) begin
        respData_q <= rdOk ? rdByte : 8'h00;
        respErr_q <= !rdOk;
      end
    end
  end

  // ****************
  // outputs
  // ****************
  assign respValid = respValid_q;
  assign respData = respData_q;
  assign respErr = respErr_q;
  assign diagIncoming = incoming_q;
  assign diagGoing = going_q;
  assign diagActive = active_q;

  // ****************
  // checks
  // ****************
  property p_sum_ch;
    @(posedge clk_sys) disable iff (sys_rst)
      sum_q[dgrs_pkg::SUM_CH] == (|map_q);
  endproperty
  a_sum_ch: assert property (p_sum_ch) else $error("channel summary bit wrong");
  property p_rsvd;
    @(posedge clk_sys) disable iff (sys_rst)
      (sum_q[6:5] == 2'h0) && (det_q[2:0] == 3'h0) && !det_q[5] && !det_q[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_incoming;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && state_q == dgrs_pkg::ST_IDLE && diagEnable && cause)
        |=> (diagIncoming && diagActive && ts_q == $past(tick.usCount));
  endproperty
  a_incoming: assert property (p_incoming) else $error("incoming missed");
  property p_frozen;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && state_q == dgrs_pkg::ST_ACTIVE && cause) |=> ($stable(sum_q) && $stable(map_q));
  endproperty
  a_frozen: assert property (p_frozen) else $error("record changed while active");
  property p_going;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && state_q == dgrs_pkg::ST_ACTIVE && !cause) |=> (diagGoing && !diagActive);
  endproperty
  a_going: assert property (p_going) else $error("going missed");
  property p_short;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && reqValid && !reqWrite && reqRecord == dgrs_pkg::DR_SHORT && reqIndex > dgrs_pkg::IX_SHORT_LAST)
        |=> (respValid && respErr);
  endproperty
  a_short: assert property (p_short) else $error("short record overrun accepted");
  property p_write;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && reqValid && reqWrite) |=> (respValid && respErr && respData == 8'h00);
  endproperty
  a_write: assert property (p_write) else $error("write not refused");
  property p_nbits;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && reqValid && !reqWrite && reqRecord == dgrs_pkg::DR_FULL && reqIndex == dgrs_pkg::IX_NBITS)
        |=> (respData == dgrs_pkg::NBITS_VAL && !respErr);
  endproperty
  a_nbits: assert property (p_nbits) else $error("bits per channel wrong");
  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      !clkEn |=> ($stable(state_q) && $stable(ts_q) && $stable(respValid) && $stable(sum_q));
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while clock enable low");
  property p_map;
    @(posedge clk_sys) disable iff (sys_rst)
      map_q == {|ch_q[7], |ch_q[6], |ch_q[5], |ch_q[4], |ch_q[3], |ch_q[2], |ch_q[1], |ch_q[0]};
  endproperty
  a_map: assert property (p_map) else $error("channel map disagrees with channel bytes");
  property p_c_tick;
    @(posedge clk_sys) tick.usStep;
  endproperty
  c_tick: cover property (p_c_tick);
  property p_c_in;
    @(posedge clk_sys) diagIncoming;
  endproperty
  c_in: cover property (p_c_in);
  property p_c_go;
    @(posedge clk_sys) diagGoing;
  endproperty
  c_go: cover property (p_c_go);
  property p_c_rd;
    @(posedge clk_sys) respValid && !respErr;
  endproperty
  c_rd: cover property (p_c_rd);
endmodule : dgrs_status_bank

// [include/dgrs_pkg.sv]
// constants of the diagnostic record bank
// assumes one 40 MHz module clock
package dgrs_pkg;
  // ****************
  // timing
  // ****************
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned CH_NUM = 8;
  // ****************
  // record numbers and byte indexes
  // ****************
  localparam logic [7:0] DR_SHORT = 8'h00;
  localparam logic [7:0] DR_FULL = 8'h01;
  localparam logic [4:0] IX_SUM = 5'h00;
  localparam logic [4:0] IX_CLASS = 5'h01;
  localparam logic [4:0] IX_DETAIL = 5'h03;
  localparam logic [4:0] IX_KIND = 5'h04;
  localparam logic [4:0] IX_NBITS = 5'h05;
  localparam logic [4:0] IX_NCH = 5'h06;
  localparam logic [4:0] IX_MAP = 5'h07;
  localparam logic [4:0] IX_CH0 = 5'h08;
  localparam logic [4:0] IX_CH7 = 5'h0F;
  localparam logic [4:0] IX_TS0 = 5'h11;
  localparam logic [4:0] IX_LAST = 5'h14;
  localparam logic [4:0] IX_SHORT_LAST = 5'h03;
  // ****************
  // field positions
  // ****************
  localparam int SUM_FAIL = 0;
  localparam int SUM_INT = 1;
  localparam int SUM_EXT = 2;
  localparam int SUM_CH = 3;
  localparam int SUM_AUX = 4;
  localparam int SUM_PAR = 7;
  localparam int DET_OVF = 3;
  localparam int DET_COMM = 4;
  localparam int DET_LOST = 6;
  localparam int CHF_CJC = 3;
  // ****************
  // fixed contents
  // ****************
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam logic [7:0] NBITS_VAL = 8'h08;
  localparam logic [7:0] NCH_VAL = 8'h08;
  typedef enum logic [6:0] {
    KIND_DI = 7'h70, KIND_AI = 7'h71, KIND_DO = 7'h72,
    KIND_AO = 7'h73, KIND_AIO = 7'h74, KIND_CNT = 7'h76
  } dgrs_kind_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ACTIVE = 2'h1, ST_GOING = 2'h3
  } dgrs_state_t;
endpackage : dgrs_pkg

// [include/dgrs_tick_if.sv]
// microsecond ticker carrier
// assumes the ticker and its users share clk_sys
`timescale 1ns/1ps
interface dgrs_tick_if;
  logic [31:0] usCount;
  logic usStep;
  modport src (output usCount, output usStep);
  modport snk (input usCount, input usStep);
endinterface : dgrs_tick_if

// [verilog/dgrs_us_ticker.sv]
// free-running 32-bit microsecond ticker
// assumes clk_sys at the rate of the package
`timescale 1ns/1ps
module dgrs_us_ticker #(
  parameter int unsigned DIV = dgrs_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  dgrs_tick_if.src tick
);
  logic [7:0] preQ;
  logic [31:0] cntQ;
  logic stepQ;
  // ****************
  // prescaler and counter
  // ****************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      preQ <= 8'h00;
      stepQ <= 1'b0;
    end else if (clkEn) begin
      stepQ <= (preQ == 8'(DIV - 1));
      preQ <= (preQ == 8'(DIV - 1)) ? 8'h00 : preQ + 8'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cntQ <= 32'h00000000;
    end else if (clkEn && stepQ) begin
      cntQ <= cntQ + 32'h00000001;
    end
  end
  assign tick.usCount = cntQ;
  assign tick.usStep = stepQ;
  property p_tick_inc;
    @(posedge clk_sys) disable iff (sys_rst)
      (clkEn && stepQ) |=> (cntQ == $past(cntQ) + 32'h00000001);
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("ticker missed a step");
  property p_tick_start;
    @(posedge clk_sys) sys_rst |=> (cntQ == 32'h00000000);
  endproperty
  a_tick_start: assert property (p_tick_start) else $error("ticker not zero at start");
endmodule : dgrs_us_ticker

// [verilog/dgrs_chan_byte.sv]
// one channel fault byte
// assumes cause inputs synchronous to clk_sys
`timescale 1ns/1ps
module dgrs_chan_byte (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic paramErr,
  input wire logic cjcInternal,
  input wire logic cjcDefect,
  input wire logic wireBreak,
  input wire logic intLost,
  input wire logic under,
  input wire logic over,
  output logic [7:0] faultByte
);
  // ****************
  // byte assembly
  // ****************
  always_comb begin
    faultByte = 8'h00;
    faultByte[0] = paramErr;
    faultByte[3] = cjcInternal & cjcDefect;
    faultByte[4] = wireBreak;
    faultByte[5] = intLost;
    faultByte[6] = under;
    faultByte[7] = over;
  end
  property p_cjc_gate;
    @(posedge clk_sys) disable iff (sys_rst)
      faultByte[3] |-> (cjcInternal && cjcDefect);
  endproperty
  a_cjc_gate: assert property (p_cjc_gate) else $error("compensation fault without cause");
endmodule : dgrs_chan_byte

// [dv/dgrs_host_model.sv]
// backplane reader issuing record requests to the bank
// assumes commands arrive synchronous to clk_sys
`timescale 1ns/1ps
module dgrs_host_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmdGo,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdRecord,
  input wire logic [4:0] cmdIndex,
  output logic reqValid = 1'b0,
  output logic reqWrite = 1'b0,
  output logic [7:0] reqRecord = 8'h00,
  output logic [4:0] reqIndex = 5'h00
);
  // ****************
  // one request per command, qualifiers scrambled when idle
  // ****************
  always @(posedge clk_sys) begin
    reqValid <= cmdGo & ~sys_rst;
    if (cmdGo) begin
      reqWrite <= cmdWrite;
      reqRecord <= cmdRecord;
      reqIndex <= cmdIndex;
    end else begin
      reqWrite <= ~reqWrite;
      reqRecord <= ~reqRecord;
      reqIndex <= ~reqIndex;
    end
  end
endmodule : dgrs_host_model

// [dv/test_diag_record_status_bank.sv]
// self-checking bench of the diagnostic record bank
// assumes the host model in dv and design files compiled first
`timescale 1ns/1ps
module test_diag_record_status_bank;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdGo = 1'b0, cmdWrite = 1'b0;
  logic [7:0] cmdRecord = 8'h00;
  logic [4:0] cmdIndex = 5'h00;
  logic reqValid, reqWrite, respValid, respErr, diagIncoming, diagGoing, diagActive;
  logic [7:0] reqRecord, respData;
  logic [4:0] reqIndex;
  logic diagEnable = 1'b0, clkEn = 1'b1;
  logic [4:0] modCause = 5'h00;
  logic [2:0] detCause = 3'h0;
  logic [7:0] cPar = 8'h00, cCjI = 8'h00, cCjD = 8'h00, cWire = 8'h00, cLost = 8'h00, cUnd = 8'h00, cOvr = 8'h00;
  logic [8:0] expQ[$];
  logic sawInc = 1'b0;
  int miscompares = 0;
  int compares = 0;
  int sumPos[5] = '{0, 1, 2, 4, 7};
  int detPos[3] = '{3, 4, 6};
  // ****************
  // clock, partner, design
  // ****************
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  dgrs_host_model host (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmdGo(cmdGo), .cmdWrite(cmdWrite),
    .cmdRecord(cmdRecord), .cmdIndex(cmdIndex), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqRecord(reqRecord), .reqIndex(reqIndex));
  dgrs_status_bank #(.TICK_DIV(2)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqRecord(reqRecord), .reqIndex(reqIndex),
    .respValid(respValid), .respData(respData), .respErr(respErr), .diagEnable(diagEnable),
    .modFail(modCause[0]), .intErr(modCause[1]), .extErr(modCause[2]), .auxMissing(modCause[3]),
    .paramErr(modCause[4]), .diagBufOvf(detCause[0]), .commErr(detCause[1]), .hwIntLost(detCause[2]),
    .chParamErr(cPar), .chCjcInternal(cCjI), .chCjcDefect(cCjD), .chWireBreak(cWire),
    .chIntLost(cLost), .chUnder(cUnd), .chOver(cOvr), .diagIncoming(diagIncoming),
    .diagGoing(diagGoing), .diagActive(diagActive));
  // ****************
  // compare tasks and verdict
  // ****************
  task automatic cmpResp(input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t resp exp=%h got=%h", $time, e, g);
    end
  endtask : cmpResp
  task automatic cmpFlag(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t flag exp=%h got=%h", $time, e, g);
    end
  endtask : cmpFlag
  task automatic finish_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // ****************
  // answer monitor
  // ****************
  always @(posedge clk_sys) begin
    if (diagIncoming === 1'b1) begin
      sawInc <= 1'b1;
    end
    if (respValid === 1'b1) begin
      if (expQ.size() == 0) begin
        miscompares++;
        $display("ERROR t=%0t unexpected answer exp=%h got=%h", $time, 9'h000, {respErr, respData});
      end else begin
        cmpResp(expQ.pop_front(), {respErr, respData});
      end
    end
  end
  // ****************
  // stimulus
  // ****************
  task automatic rd(input logic [7:0] r, input logic [4:0] i, input logic w, input logic [8:0] e);
    @(posedge clk_sys);
    cmdGo <= 1'b1;
    cmdWrite <= w;
    cmdRecord <= r;
    cmdIndex <= i;
    expQ.push_back(e);
    @(posedge clk_sys);
    cmdGo <= 1'b0;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle
  task automatic waitFlag(input bit going);
    int n;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      if ((going ? diagGoing : diagIncoming) === 1'b1) begin
        return;
      end
    end
    miscompares++;
    $display("ERROR t=%0t no diag pulse exp=%h got=%h", $time, 1'b1, 1'b0);
    finish_test();
  endtask : waitFlag
  initial begin
    logic [6:0] f;
    logic [7:0] b;
    int k;
    void'($urandom(32'h43C608D3));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h01, 5'h1, 1'b0, 9'h015);
    rd(8'h01, 5'h2, 1'b0, 9'h000);
    rd(8'h01, 5'h4, 1'b0, 9'h071);
    rd(8'h01, 5'h5, 1'b0, 9'h008);
    rd(8'h01, 5'h6, 1'b0, 9'h008);
    rd(8'h01, 5'h10, 1'b0, 9'h000);
    for (k = 17; k <= 20; k++) begin
      rd(8'h01, k[4:0], 1'b0, 9'h000);
    end
    for (k = 0; k < 4; k++) begin
      rd(8'h00, k[4:0], 1'b0, (k == 1) ? 9'h015 : 9'h000);
    end
    rd(8'h00, 5'h4, 1'b0, 9'h100);
    rd(8'h02, 5'h0, 1'b0, 9'h100);
    rd(8'h01, 5'h15, 1'b0, 9'h100);
    rd(8'h01, 5'h1, 1'b1, 9'h100);
    $display("test access done");
    for (k = 0; k < 5; k++) begin
      modCause <= 5'h01 << k;
      settle();
      rd(8'h01, 5'h0, 1'b0, {1'b0, 8'h01 << sumPos[k]});
    end
    modCause <= 5'h00;
    for (k = 0; k < 3; k++) begin
      detCause <= 3'h1 << k;
      settle();
      rd(8'h01, 5'h3, 1'b0, {1'b0, 8'h01 << detPos[k]});
    end
    detCause <= 3'h0;
    $display("test module bytes done");
    for (k = 0; k < 8; k++) begin
      f = 7'($urandom);
      cPar <= {7'h00, f[0]} << k;
      cCjI <= {7'h00, f[1]} << k;
      cCjD <= {7'h00, f[2]} << k;
      cWire <= {7'h00, f[3]} << k;
      cLost <= {7'h00, f[4]} << k;
      cUnd <= {7'h00, f[5]} << k;
      cOvr <= {7'h00, f[6]} << k;
      b = {f[6], f[5], f[4], f[3], f[1] & f[2], 2'h0, f[0]};
      settle();
      rd(8'h01, 5'(8 + k), 1'b0, {1'b0, b});
      rd(8'h01, 5'h7, 1'b0, {1'b0, (b != 8'h00) ? (8'h01 << k) : 8'h00});
      rd(8'h00, 5'h0, 1'b0, {1'b0, (b != 8'h00) ? 8'h08 : 8'h00});
    end
    cmpFlag(1'b0, sawInc);
    rd(8'h01, 5'h11, 1'b0, 9'h000);
    $display("test channel bytes done");
    settle();
    clkEn <= 1'b0;
    cPar <= 8'h00;
    cCjI <= 8'h00;
    cCjD <= 8'h00;
    cLost <= 8'h00;
    cUnd <= 8'h00;
    cOvr <= 8'h00;
    cWire <= 8'h04;
    diagEnable <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmpFlag(1'b0, diagActive);
    clkEn <= 1'b1;
    waitFlag(1'b0);
    cmpFlag(1'b1, diagActive);
    cOvr <= 8'h20;
    settle();
    rd(8'h01, 5'hA, 1'b0, 9'h010);
    rd(8'h01, 5'hD, 1'b0, 9'h000);
    rd(8'h01, 5'h7, 1'b0, 9'h004);
    cWire <= 8'h00;
    cOvr <= 8'h00;
    waitFlag(1'b1);
    cmpFlag(1'b0, diagActive);
    rd(8'h01, 5'hA, 1'b0, 9'h000);
    rd(8'h01, 5'h0, 1'b0, 9'h000);
    $display("test diag sequence done");
    for (k = 0; k < 20 && expQ.size() != 0; k++) begin
      @(posedge clk_sys);
    end
    if (expQ.size() != 0) begin
      miscompares++;
      $display("ERROR t=%0t answers missing exp=%h got=%h", $time, 0, expQ.size());
    end
    finish_test();
  end
endmodule : test_diag_record_status_bank
